// [uart_mdrop_pkg.sv]
// Shared constants and types for the multidrop serial transceiver.
// Assumes an 8-bit register port and a single system clock.
`default_nettype none
package uart_mdrop_pkg;
    localparam int ADDR_W = 4;
    // Register offsets
    localparam logic [3:0] OFS_DATA  = 4'h0;
    localparam logic [3:0] OFS_STAT0 = 4'h1;
    localparam logic [3:0] OFS_CTL0  = 4'h2;
    localparam logic [3:0] OFS_CTL1  = 4'h3;
    localparam logic [3:0] OFS_STAT1 = 4'h4;
    localparam logic [3:0] OFS_ADDR  = 4'h5;
    localparam logic [3:0] OFS_BRGH  = 4'h6;
    localparam logic [3:0] OFS_BRGL  = 4'h7;
    // Control 0 fields
    localparam int C0_TEN   = 7;
    localparam int C0_REN   = 6;
    localparam int C0_PEN   = 4;
    localparam int C0_PSEL  = 3;
    localparam int C0_STOP2 = 1;
    // Control 1 fields
    localparam int C1_MODE1 = 7;
    localparam int C1_MULTIDROP_ENABLE  = 6;
    localparam int C1_MODE0 = 5;
    localparam int C1_TX_MARKER_SELECT  = 4;
    localparam int C1_DRIVE_ON_POLARITY = 3;
    localparam int C1_DIVIDER_TIMER_IRQ_ENABLE  = 2;
    localparam int C1_RDDIS = 1;
    // Reset values
    localparam logic [7:0]  CTL0_RESET = 8'h00;
    localparam logic [7:0]  CTL1_RESET = 8'h00;
    localparam logic [15:0] BRG_RESET  = 16'h0002;
    // Sample ticks per serial bit, and last data bit index
    localparam logic [3:0]  OVS_LAST   = 4'hf;
    localparam logic [3:0]  OVS_MID    = 4'h7;
    localparam logic [3:0]  LAST_BIT   = 4'h7;
    // One received character
    typedef struct packed {
        logic [7:0] data;
        logic       ninth;
        logic       parErr;
        logic       frameErr;
        logic       brk;
    } rx_char_t;
endpackage
`default_nettype wire

// [uart_mdrop.sv]
// Serial transceiver with 9-bit multidrop filtering, drive-enable
// output, receive overrun handling and a divider usable as a timer.
// Assumes a register master on clk_sys; rxd arrives from a pin.
//
// Notes on behaviour
// - Multidrop frames send marker bit after eight data bits, before stop.
// - In multidrop mode the ninth bit carries the marker, not parity.
// - Scheme 01: address characters interrupt, data characters never do.
// - Scheme 00: every character interrupts; marker flag shows new frame.
// - Scheme 10: mismatched address and its data ignored; match interrupts.
// - Hardware schemes flag new frame only on first data character.
// - Each later address is compared again; mismatch ignores until match.
// - Scheme 11: like 10 but matching addresses raise no interrupt.
// - Drive-on covers whole frame, starts at data write, polarity bit.
// - Drive-on leads start bit by one to two bit periods.
// - Drive-on drops one clock after last stop bit.
// - Back-to-back characters keep drive-on active without gap.
// - Transmit interrupt when holding empty sets, after first data bit.
// - Writing transmit data clears holding-empty flag at once.
// - Receive interrupt: data, break, overrun, framing; data maskable.
// - On overrun keep unread data, withhold overrun and break until read.
// - After read, overrun shows with data available; reread clears errors.
// - Timer interrupt enable raises receive interrupt on divider reload.
// - Bit rate is system clock over sixteen times the divisor.
// - With both enables off the divider acts as a timer.
// - Reading receive data clears available, parity, framing, break flags.
`default_nettype none
module uart_mdrop
    import uart_mdrop_pkg::*;
(
    input  wire logic              clk_sys,
    input  wire logic              srst,
    input  wire logic [ADDR_W-1:0] regAddr,
    input  wire logic [7:0]        regWdata,
    input  wire logic              regWr,
    input  wire logic              regRd,
    output logic      [7:0]        regRdata,
    input  wire logic              rxd,
    output logic                   txd,
    output logic                   transceiverDriveOn,
    output logic                   txIrq,
    output logic                   rxIrq
);
    typedef enum {TX_IDLE, TX_LEAD, TX_START, TX_DATA, TX_NINTH,
                  TX_STOP, TX_TAIL} tx_state_t;
    typedef enum {RX_IDLE, RX_START, RX_BITS, RX_STOP,
                  RX_HOLD} rx_state_t;

    logic [7:0]  ctl0_reg, ctl1_reg, addrCmp_reg, brgHi_reg, brgLo_reg;
    logic [15:0] brgCnt_reg;
    logic [3:0]  txSub_reg;
    tx_state_t   txState_reg;
    logic [7:0]  hold_reg, txSh_reg;
    logic        holdFull_reg, holdEmpty_reg, txNinth_reg, leadSeen_reg;
    logic        stopIdx_reg;
    logic [3:0]  txIdx_reg;
    rx_state_t   rxState_reg;
    logic [1:0]  rxSync_reg;
    logic [3:0]  rxSub_reg, rxIdx_reg;
    logic [8:0]  rxSh_reg;
    logic [7:0]  rxData_reg;
    logic        avail_reg, parErr_reg, frameErr_reg, brk_reg, ovr_reg;
    logic        pendOvr_reg, pendBrk_reg, marker_reg, newFrame_reg;
    logic        matched_reg, firstData_reg;

    // Decoded control fields
    wire logic       txEnable  = ctl0_reg[C0_TEN];
    wire logic       rxEnable  = ctl0_reg[C0_REN];
    wire logic       mpEnable  = ctl1_reg[C1_MULTIDROP_ENABLE];
    wire logic [1:0] scheme    = {ctl1_reg[C1_MODE1], ctl1_reg[C1_MODE0]};
    wire logic       ninthUsed = mpEnable | ctl0_reg[C0_PEN];
    wire logic [15:0] divisor  = {brgHi_reg, brgLo_reg};

    // Register port decode
    wire logic wrData = regWr && regAddr == OFS_DATA;
    wire logic rdData = regRd && regAddr == OFS_DATA;

    // Divider: reload pulse doubles as 16x sample tick and timer event
    wire logic reload = brgCnt_reg <= 16'h0001;
    wire logic sampleTick = reload && (txEnable || rxEnable);
    wire logic bitTick = sampleTick && txSub_reg == OVS_LAST;

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            brgCnt_reg <= BRG_RESET;
            txSub_reg  <= 4'h0;
        end else begin
            brgCnt_reg <= reload ? divisor : brgCnt_reg - 16'h0001;
            if (sampleTick)
                txSub_reg <= txSub_reg + 4'h1;
        end
    end

    // Software-written registers
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            ctl0_reg    <= CTL0_RESET;
            ctl1_reg    <= CTL1_RESET;
            addrCmp_reg <= 8'h00;
            brgHi_reg   <= BRG_RESET[15:8];
            brgLo_reg   <= BRG_RESET[7:0];
        end else if (regWr) begin
            case (regAddr)
                OFS_CTL0: ctl0_reg    <= regWdata;
                OFS_CTL1: ctl1_reg    <= regWdata;
                OFS_ADDR: addrCmp_reg <= regWdata;
                OFS_BRGH: brgHi_reg   <= regWdata;
                OFS_BRGL: brgLo_reg   <= regWdata;
                default:  ;
            endcase
        end
    end

    // Transmit ninth bit: marker in multidrop, else parity
    wire logic parityOut = ^hold_reg ^ ctl0_reg[C0_PSEL];
    wire logic ninthOut = mpEnable ? ctl1_reg[C1_TX_MARKER_SELECT] : parityOut;
    wire logic loadNow = holdFull_reg && txEnable;
    wire logic firstBitDone = txState_reg == TX_DATA && bitTick
                              && txIdx_reg == 4'h0;

    // Transmit sequencer
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            txState_reg  <= TX_IDLE;
            holdFull_reg <= 1'b0;
            hold_reg     <= 8'h00;
            txSh_reg     <= 8'h00;
            txNinth_reg  <= 1'b0;
            txIdx_reg    <= 4'h0;
            leadSeen_reg <= 1'b0;
            stopIdx_reg  <= 1'b0;
        end else begin
            if (wrData) begin
                hold_reg     <= regWdata;
                holdFull_reg <= 1'b1;
            end
            case (txState_reg)
                TX_IDLE: begin
                    leadSeen_reg <= 1'b0;
                    if (loadNow)
                        txState_reg <= TX_LEAD;
                end
                TX_LEAD: begin
                    // First tick ends a partial period, second starts the
                    // frame, so the lead is one to two bit periods
                    if (bitTick) begin
                        leadSeen_reg <= 1'b1;
                        if (leadSeen_reg)
                            txState_reg <= TX_START;
                    end
                end
                TX_START: begin
                    if (bitTick) begin
                        txState_reg <= TX_DATA;
                        txIdx_reg   <= 4'h0;
                    end
                end
                TX_DATA: begin
                    if (bitTick) begin
                        txIdx_reg <= txIdx_reg + 4'h1;
                        if (txIdx_reg == LAST_BIT)
                            txState_reg <= ninthUsed ? TX_NINTH : TX_STOP;
                        stopIdx_reg <= 1'b0;
                    end
                end
                TX_NINTH: begin
                    if (bitTick)
                        txState_reg <= TX_STOP;
                end
                TX_STOP: begin
                    if (bitTick) begin
                        stopIdx_reg <= 1'b1;
                        if (!ctl0_reg[C0_STOP2] || stopIdx_reg)
                            txState_reg <= loadNow ? TX_START
                                                   : TX_TAIL;
                    end
                end
                TX_TAIL: begin
                    leadSeen_reg <= 1'b0;
                    txState_reg <= loadNow ? TX_LEAD : TX_IDLE;
                end
                default: txState_reg <= TX_IDLE;
            endcase
            // Holding register moves to the shifter as the frame starts
            if ((txState_reg == TX_LEAD && bitTick && leadSeen_reg) ||
                (txState_reg == TX_STOP && bitTick && loadNow &&
                 (!ctl0_reg[C0_STOP2] || stopIdx_reg))) begin
                txSh_reg     <= hold_reg;
                txNinth_reg  <= ninthOut;
                holdFull_reg <= wrData;
            end
        end
    end

    // Empty flag: a write clears it even against the first-bit event,
    // since the holding register is then genuinely full again
    always_ff @(posedge clk_sys) begin
        if (srst)
            holdEmpty_reg <= 1'b1;
        else if (wrData)
            holdEmpty_reg <= 1'b0;
        else if (firstBitDone && !holdFull_reg)
            holdEmpty_reg <= 1'b1;
    end

    // Line level and drive-on, both registered for equal delay
    wire logic txBusy = txState_reg != TX_IDLE;
    wire logic lineNext = txState_reg == TX_START ? 1'b0 :
                          txState_reg == TX_DATA  ? txSh_reg[txIdx_reg[2:0]] :
                          txState_reg == TX_NINTH ? txNinth_reg : 1'b1;
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            txd                <= 1'b1;
            transceiverDriveOn <= 1'b0;
            txIrq              <= 1'b0;
        end else begin
            txd                <= lineNext;
            transceiverDriveOn <= txBusy ^ ctl1_reg[C1_DRIVE_ON_POLARITY];
            txIrq              <= holdEmpty_reg;
        end
    end

    // Receive shifter, oversampled; rxSync_reg[1] is the usable level
    wire logic rxLine = rxSync_reg[1];
    wire logic [3:0] rxBits = ninthUsed ? 4'h9 : 4'h8;
    wire logic rxSample = sampleTick && rxSub_reg == OVS_LAST;
    wire logic rxDone = rxState_reg == RX_STOP && rxSample;
    rx_char_t rxChar;
    assign rxChar.data  = ninthUsed ? rxSh_reg[7:0] : rxSh_reg[8:1];
    assign rxChar.ninth = ninthUsed & rxSh_reg[8];
    assign rxChar.parErr = ctl0_reg[C0_PEN] && !mpEnable &&
        (rxChar.ninth != (^rxChar.data ^ ctl0_reg[C0_PSEL]));
    assign rxChar.frameErr = !rxLine;
    assign rxChar.brk = !rxLine && rxChar.data == 8'h00 && !rxChar.ninth;

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            rxSync_reg  <= 2'b11;
            rxState_reg <= RX_IDLE;
            rxSub_reg   <= 4'h0;
            rxIdx_reg   <= 4'h0;
            rxSh_reg    <= 9'h000;
        end else begin
            rxSync_reg <= {rxSync_reg[0], rxd};
            if (sampleTick)
                rxSub_reg <= rxSub_reg + 4'h1;
            case (rxState_reg)
                RX_IDLE: begin
                    rxSub_reg <= 4'h0;
                    if (!rxLine && rxEnable)
                        rxState_reg <= RX_START;
                end
                RX_START: begin
                    if (sampleTick && rxSub_reg == OVS_MID) begin
                        rxSub_reg   <= 4'h0;
                        rxIdx_reg   <= 4'h0;
                        rxState_reg <= rxLine ? RX_IDLE : RX_BITS;
                    end
                end
                RX_BITS: begin
                    if (rxSample) begin
                        rxSh_reg  <= {rxLine, rxSh_reg[8:1]};
                        rxIdx_reg <= rxIdx_reg + 4'h1;
                        if (rxIdx_reg == rxBits - 4'h1)
                            rxState_reg <= RX_STOP;
                    end
                end
                RX_STOP: begin
                    // A low stop bit waits for the line to recover
                    if (rxSample)
                        rxState_reg <= rxLine ? RX_IDLE : RX_HOLD;
                end
                RX_HOLD: begin
                    if (rxLine)
                        rxState_reg <= RX_IDLE;
                end
                default: rxState_reg <= RX_IDLE;
            endcase
        end
    end

    // Multidrop filter
    wire logic isAddr = rxChar.ninth;
    wire logic addrHit = rxChar.data == addrCmp_reg;
    wire logic hwMatch = scheme[1];
    wire logic keepChar =
        !mpEnable ? 1'b1 :
        scheme == 2'b01 ? isAddr :
        scheme == 2'b00 ? 1'b1 :
        isAddr ? (scheme == 2'b10 && addrHit)
               : matched_reg;
    wire logic accept = rxDone && keepChar;
    wire logic store = accept && (!avail_reg || rdData) && !pendOvr_reg;
    wire logic overrun = accept && !store;

    // Receive data and status; a read releases withheld overrun status
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            rxData_reg <= 8'h00;
            avail_reg  <= 1'b0;
            parErr_reg <= 1'b0;
            frameErr_reg <= 1'b0;
            brk_reg    <= 1'b0;
            ovr_reg    <= 1'b0;
            pendOvr_reg <= 1'b0;
            pendBrk_reg <= 1'b0;
            marker_reg <= 1'b0;
            newFrame_reg <= 1'b0;
            matched_reg <= 1'b0;
            firstData_reg <= 1'b0;
        end else begin
            if (rxDone && mpEnable && hwMatch && isAddr) begin
                matched_reg   <= addrHit;
                firstData_reg <= addrHit;
            end else if (store && !isAddr)
                firstData_reg <= 1'b0;
            if (overrun) begin
                pendOvr_reg <= 1'b1;
                pendBrk_reg <= pendBrk_reg | rxChar.brk;
            end
            if (rdData && pendOvr_reg) begin
                avail_reg   <= 1'b1;
                ovr_reg     <= 1'b1;
                brk_reg     <= pendBrk_reg;
                pendOvr_reg <= overrun;
                pendBrk_reg <= overrun & rxChar.brk;
            end else if (store) begin
                rxData_reg   <= rxChar.data;
                avail_reg    <= 1'b1;
                parErr_reg   <= rxChar.parErr;
                frameErr_reg <= rxChar.frameErr;
                brk_reg      <= rxChar.brk;
                ovr_reg      <= 1'b0;
                marker_reg   <= rxChar.ninth;
                newFrame_reg <= hwMatch && !isAddr && firstData_reg;
            end else if (rdData) begin
                avail_reg    <= 1'b0;
                parErr_reg   <= 1'b0;
                frameErr_reg <= 1'b0;
                brk_reg      <= 1'b0;
                ovr_reg      <= 1'b0;
            end
        end
    end

    // Receive interrupt sources, data source separately masked
    wire logic rxSrc = (avail_reg && !ctl1_reg[C1_RDDIS]) || ovr_reg ||
                       frameErr_reg || brk_reg;
    wire logic timerEvt = ctl1_reg[C1_DIVIDER_TIMER_IRQ_ENABLE] && reload;

    // Read mux and registered outputs
    wire logic [7:0] stat0 = {avail_reg, parErr_reg, ovr_reg, frameErr_reg,
                              brk_reg, holdEmpty_reg, !txBusy, 1'b0};
    wire logic [7:0] rdMux =
        regAddr == OFS_DATA  ? rxData_reg :
        regAddr == OFS_STAT0 ? stat0 :
        regAddr == OFS_CTL0  ? ctl0_reg :
        regAddr == OFS_CTL1  ? ctl1_reg :
        regAddr == OFS_STAT1 ? {6'h00, newFrame_reg, marker_reg} :
        regAddr == OFS_ADDR  ? addrCmp_reg :
        regAddr == OFS_BRGH  ? brgHi_reg :
        regAddr == OFS_BRGL  ? brgLo_reg : 8'h00;
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            regRdata <= 8'h00;
            rxIrq    <= 1'b0;
        end else begin
            regRdata <= regRd ? rdMux : 8'h00;
            rxIrq    <= rxSrc || timerEvt;
        end
    end

    // Helper: cycles of drive-on before the start bit
    logic [19:0] leadCnt_reg;
    always_ff @(posedge clk_sys) begin
        if (srst || txState_reg != TX_LEAD)
            leadCnt_reg <= 20'h00000;
        else
            leadCnt_reg <= leadCnt_reg + 20'h00001;
    end
    wire logic [19:0] bitCycles = {divisor, 4'h0};

    chk_hold_clear: assert property (@(posedge clk_sys)
        disable iff (srst)
        wrData |=> !holdEmpty_reg) else $error("empty flag not cleared");
    chk_lead_window: assert property (@(posedge clk_sys)
        disable iff (srst)
        (txState_reg == TX_LEAD && $past(txState_reg) == TX_LEAD
         && txState_reg != TX_START) ##1 txState_reg == TX_START
        |-> leadCnt_reg >= bitCycles && leadCnt_reg <= {bitCycles[18:0], 1'b0})
        else $error("drive-on lead out of window");
    // Drive-on is registered: a polarity write lands one cycle later
    chk_drive_frame: assert property (@(posedge clk_sys)
        disable iff (srst)
        (txBusy && $stable(ctl1_reg)) |=>
        transceiverDriveOn == !$past(ctl1_reg[C1_DRIVE_ON_POLARITY]))
        else $error("drive-on not active during frame");
    chk_drive_drop: assert property (@(posedge clk_sys)
        disable iff (srst)
        (txState_reg == TX_TAIL && !loadNow && $stable(ctl1_reg)) |=> ##1
        transceiverDriveOn == $past(ctl1_reg[C1_DRIVE_ON_POLARITY]))
        else $error("drive-on did not drop");
    chk_ovr_keep: assert property (@(posedge clk_sys)
        disable iff (srst)
        overrun |=> $stable(rxData_reg) && !ovr_reg)
        else $error("overrun disturbed held data");
    chk_ovr_show: assert property (@(posedge clk_sys)
        disable iff (srst)
        (rdData && pendOvr_reg) |=> ovr_reg && avail_reg)
        else $error("overrun not shown after read");
    chk_read_clear: assert property (@(posedge clk_sys)
        disable iff (srst)
        (rdData && !pendOvr_reg && !accept) |=> !avail_reg && !brk_reg)
        else $error("read did not clear status");
    chk_timer_irq: assert property (@(posedge clk_sys)
        disable iff (srst)
        timerEvt |=> rxIrq) else $error("timer reload missed");
    chk_addr_miss: assert property (@(posedge clk_sys)
        disable iff (srst)
        (rxDone && mpEnable && hwMatch && isAddr && !addrHit) |-> !store)
        else $error("mismatched address stored");

    cov_back_to_back: cover property (@(posedge clk_sys) disable iff (srst)
        txState_reg == TX_STOP ##1 txState_reg == TX_START);
    cov_overrun: cover property (@(posedge clk_sys) disable iff (srst)
        overrun);
    cov_new_frame: cover property (@(posedge clk_sys) disable iff (srst)
        store && hwMatch && firstData_reg && !isAddr);
endmodule
`default_nettype wire

// [serial_node.sv]
// Far node on the shared serial bus: sends 9-bit characters.
// Assumes the bench gives the bit length in system clocks.
`default_nettype none
module serial_node (
    input  wire logic clk_sys,
    output logic      line
);
    timeunit 1ns;
    timeprecision 1ns;
    // Line idles high between characters, as with a pull-up
    initial line = 1'b1;
    // Start, eight data LSB first, marker, one stop
    task automatic send(input logic [7:0] d, input logic m, input int n);
        logic [10:0] f;
        f = {1'b1, m, d, 1'b0};
        for (int i = 0; i < 11; i++) begin
            @(posedge clk_sys);
            line <= f[i];
            repeat (n - 1) @(posedge clk_sys);
        end
    endtask
endmodule
`default_nettype wire

// [testbench.sv]
// Bench for the multidrop serial transceiver: register tasks, far node.
// Assumes divisor 1, so one bit lasts 16 system clocks.
`default_nettype none
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin \
    fails++; $display("mismatch %s exp %h got %h", n, e, g); end end
module testbench;
    import uart_mdrop_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic              clk_sys, srst, regWr, regRd, rxd, txd;
    logic              driveOn, txIrq, rxIrq, watch;
    logic [ADDR_W-1:0] regAddr;
    logic [7:0]        regWdata, regRdata, d;
    logic [8:0]        f1, f2;
    int                fails, total_checks, lead, gaps, n;
    uart_mdrop DUT (.clk_sys(clk_sys), .srst(srst), .regAddr(regAddr),
        .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
        .regRdata(regRdata), .rxd(rxd), .txd(txd),
        .transceiverDriveOn(driveOn), .txIrq(txIrq), .rxIrq(rxIrq));
    serial_node node (.clk_sys(clk_sys), .line(rxd));
    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end
    // Lead before start, and any drop of drive-on inside a burst
    always @(posedge clk_sys) begin
        lead <= (driveOn !== 1'b1) ? 0 : lead + (txd === 1'b1);
        gaps <= gaps + (watch && driveOn !== 1'b1);
    end
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge clk_sys);
        regAddr <= a; regWdata <= v; regWr <= 1'b1;
        @(posedge clk_sys);
        regWr <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, output logic [7:0] v);
        @(posedge clk_sys);
        regAddr <= a; regRd <= 1'b1;
        @(posedge clk_sys);
        regRd <= 1'b0;
        #1 v = regRdata;
    endtask
    // Samples the nine bits mid-bit after the start edge
    task automatic grab(output logic [8:0] b);
        int w;
        w = 0;
        while (txd !== 1'b0 && w < 3000) begin @(posedge clk_sys); #1 w++; end
        repeat (8) @(posedge clk_sys);
        for (int i = 0; i < 9; i++) begin
            repeat (16) @(posedge clk_sys);
            #1 b[i] = txd;
        end
        repeat (16) @(posedge clk_sys);
        #1 `CHK("stop", 1'b1, txd);
    endtask
    task automatic rx(input logic [7:0] c, input logic m, input logic irq);
        node.send(c, m, 16);
        repeat (4) @(posedge clk_sys);
        #1 `CHK("rxIrq", irq, rxIrq);
    endtask
    task automatic rdv(input logic [3:0] a, input int b, input logic e);
        rd(a, d);
        `CHK("statbit", e, d[b]);
    endtask
    task automatic complete_run;
        if (fails == 0 && total_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // Watchdog sized well above the whole sequence
    initial begin
        repeat (30000) @(posedge clk_sys);
        fails++;
        complete_run();
    end
    initial begin
        srst = 1'b1; regAddr = '0; regWdata = '0; regWr = 1'b0;
        regRd = 1'b0; watch = 1'b0; fails = 0; total_checks = 0; gaps = 0;
        repeat (3) @(posedge clk_sys);
        srst <= 1'b0;
        rd(OFS_STAT0, d); `CHK("stat0", 8'h06, d);
        rd(OFS_BRGL, d); `CHK("brgl", 8'h02, d);
        rd(4'h9, d); `CHK("unmapped", 8'h00, d);
        wr(OFS_BRGL, 8'h01); wr(OFS_BRGH, 8'h00);
        wr(OFS_CTL1, 8'h50); wr(OFS_CTL0, 8'hc0);
        wr(OFS_DATA, 8'ha5);
        fork
            begin grab(f1); grab(f2); end
            begin
                rdv(OFS_STAT0, 2, 1'b0);
                watch = 1'b1;
                n = 0;
                while (txIrq !== 1'b1 && n < 200) begin
                    @(posedge clk_sys); #1 n++;
                end
                `CHK("txIrqAt", 1'b1, n >= 40 && n <= 70);
                wr(OFS_CTL1, 8'h40); wr(OFS_DATA, 8'h3c);
            end
            begin
                @(negedge txd);
                `CHK("lead", 1'b1, lead >= 16 && lead <= 32);
            end
        join
        n = 0;
        while (driveOn !== 1'b0 && n < 40) begin
            @(posedge clk_sys);
            #1 n++;
        end
        watch = 1'b0;
        `CHK("frame1", 9'h1a5, f1);
        `CHK("frame2", 9'h03c, f2);
        `CHK("gaps", 0, gaps);
        `CHK("tail", 1'b1, n >= 8 && n <= 11);
        wr(OFS_CTL1, 8'h08);
        // Drive-on is registered, so the new level shows one edge later
        @(posedge clk_sys);
        #1 `CHK("pol", 1'b1, driveOn);
        // Plain framing: even parity in the ninth slot, two stop bits
        wr(OFS_CTL0, 8'hd2); wr(OFS_DATA, 8'h07);
        grab(f1);
        `CHK("parity", 9'h107, f1);
        repeat (16) @(posedge clk_sys);
        #1 `CHK("stop2", 1'b0, driveOn);
        wr(OFS_CTL0, 8'hc0);
        wr(OFS_ADDR, 8'h42); wr(OFS_CTL1, 8'hc0);
        rx(8'h17, 1'b1, 1'b0); rx(8'h11, 1'b0, 1'b0);
        rx(8'h42, 1'b1, 1'b1); rd(OFS_DATA, d);
        `CHK("addr", 8'h42, d);
        rx(8'h99, 1'b0, 1'b1); rdv(OFS_STAT1, 1, 1'b1);
        rd(OFS_DATA, d); `CHK("data", 8'h99, d);
        rx(8'h55, 1'b0, 1'b1); rdv(OFS_STAT1, 1, 1'b0);
        rdv(OFS_DATA, 0, 1'b1); rdv(OFS_STAT0, 7, 1'b0);
        rx(8'h43, 1'b1, 1'b0); rx(8'h66, 1'b0, 1'b0);
        wr(OFS_CTL1, 8'he0);
        rx(8'h42, 1'b1, 1'b0); rx(8'h77, 1'b0, 1'b1);
        rdv(OFS_STAT1, 1, 1'b1); rd(OFS_DATA, d);
        wr(OFS_CTL1, 8'h60);
        rx(8'h05, 1'b1, 1'b1); rd(OFS_DATA, d);
        rx(8'h33, 1'b0, 1'b0);
        wr(OFS_CTL1, 8'h40);
        rx(8'h33, 1'b0, 1'b1); rdv(OFS_STAT1, 0, 1'b0);
        rd(OFS_DATA, d);
        rx(8'h88, 1'b1, 1'b1); rdv(OFS_STAT1, 0, 1'b1);
        rd(OFS_DATA, d);
        wr(OFS_CTL1, 8'h00);
        rx(8'h12, 1'b1, 1'b1); rx(8'h34, 1'b1, 1'b1);
        rdv(OFS_STAT0, 5, 1'b0); rd(OFS_DATA, d);
        `CHK("kept", 8'h12, d);
        rdv(OFS_STAT0, 5, 1'b1); rdv(OFS_STAT0, 7, 1'b1);
        rd(OFS_DATA, d); rdv(OFS_STAT0, 5, 1'b0);
        wr(OFS_CTL1, 8'h02); rx(8'h21, 1'b1, 1'b0);
        rd(OFS_DATA, d);
        wr(OFS_CTL0, 8'h00); wr(OFS_BRGL, 8'h05); wr(OFS_CTL1, 8'h04);
        n = 0;
        while (rxIrq !== 1'b1 && n < 50) begin @(posedge clk_sys); #1 n++; end
        n = 0;
        do begin @(posedge clk_sys); #1 n++; end
        while (rxIrq !== 1'b1 && n < 50);
        `CHK("interval", 5, n);
        complete_run();
    end
endmodule
`default_nettype wire
